// >>> logic/mcsafc_channel.sv
/*
  One current channel front end: decodes input select into switch controls,
  gain select into gain factor and full-scale range.
  Assumes codes are steady when sampled by this block's output registers.
*/
`timescale 1ns/10ps
`include "mcsafc_defines.svh"
module mcsafc_channel
  import mcsafc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic [1:0] mux_sel,
  input  wire logic [1:0] gain_sel,
  // Switch controls: positive, ground short, direct, crossed, test DAC
  output logic [4:0]      switches_r,
  output logic [5:0]      gain_r,
  output logic [20:0]     fsr_uv_r
);
  logic [4:0]  switches_nxt; // Decoded switch pattern
  logic [5:0]  gain_nxt;     // Decoded gain
  logic [20:0] fsr_nxt;      // Full scale in microvolts

  // Switch pattern per input code
  always_comb begin
    unique case (mux_sel)
      `MCSAFC_MUX_NORMAL:  switches_nxt = 5'h14;
      `MCSAFC_MUX_SWAPPED: switches_nxt = 5'h12;
      `MCSAFC_MUX_SHORT:   switches_nxt = 5'h0c;
      `MCSAFC_MUX_TESTDAC: switches_nxt = 5'h05;
    endcase
  end

  // Gain doubles per code step; range shrinks with it
  always_comb begin
    gain_nxt = 6'h04 << gain_sel;
    fsr_nxt  = `MCSAFC_FSR_UV >> (5'd2 + {3'h0, gain_sel});
  end

  // Register outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      switches_r <= 5'h14;
      gain_r     <= 6'h04;
      fsr_uv_r   <= 21'h04c4b4;
    end else begin
      switches_r <= switches_nxt;
      gain_r     <= gain_nxt;
      fsr_uv_r   <= fsr_nxt;
    end
  end
endmodule : mcsafc_channel

// >>> logic/mcsafc_top.sv
/*
  Main clock source selection, modulator enable divider, diagnostic clock
  enable and per-section current channel front control.
  Assumes one CLOCK; the source is chosen by CLOCK_SOURCE alone;
  host quiesces converters before changing source.
*/
`timescale 1ns/10ps
`include "mcsafc_defines.svh"
module mcsafc_top
  import mcsafc_pkg::*;
#(
  parameter int DIAG_DIV = 8 // Diagnostic oscillator enable ratio
)(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // Configuration
  input  wire logic        CLOCK_SOURCE,
  input  wire logic [1:0]  CONVERTERS_ENABLE,
  input  wire logic [1:0]  MUX_SEL_A,
  input  wire logic [1:0]  GAIN_SEL_A,
  input  wire logic [1:0]  MUX_SEL_B,
  input  wire logic [1:0]  GAIN_SEL_B,
  // Clock status
  output logic             ACTIVE_SOURCE,
  output logic             MAIN_CLOCK_RUN,
  output logic             MOD_CLOCK,
  output logic             DIAG_TICK,
  // Section A front end
  output logic [4:0]       SWITCHES_A,
  output logic [5:0]       GAIN_A,
  output logic [20:0]      FSR_UV_A,
  // Section B front end
  output logic [4:0]       SWITCHES_B,
  output logic [5:0]       GAIN_B,
  output logic [20:0]      FSR_UV_B
);
  // Divider counter is 16 bits wide; a ratio below 2 leaves no idle cycle
  if (DIAG_DIV < 2 || DIAG_DIV > 65536) begin : g_bad_div
    $error("DIAG_DIV must lie between 2 and 65536");
  end

  // Clock is released only in the run state; used by the run_nxt next-value path
  function automatic logic is_run(mcsafc_state_t st);
    return (st == MCSAFC_ST_RUN);
  endfunction : is_run

  mcsafc_state_t st_r, st_nxt;   // Switchover state
  logic          run_r, run_nxt; // Main clock released, registered for the port
  logic          src_r, src_nxt; // Selected source
  logic [2:0]    cnt_r, cnt_nxt; // Settle counter
  logic          mod_r, mod_nxt; // Modulator clock level
  logic [15:0]   dcnt_r, dcnt_nxt; // Diagnostic divider
  logic          dtick_r, dtick_nxt;

  // Source change waits until converters idle; glitch-free hold window
  always_comb begin
    st_nxt  = st_r;
    src_nxt = src_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      MCSAFC_ST_RUN: begin
        // Taken only once both converter enables are low
        if (CLOCK_SOURCE != src_r && CONVERTERS_ENABLE == 2'h0) begin
          st_nxt  = MCSAFC_ST_HOLD;
          cnt_nxt = 3'd0;
        end
      end
      MCSAFC_ST_HOLD: begin
        src_nxt = CLOCK_SOURCE;
        st_nxt  = MCSAFC_ST_SWAP;
      end
      MCSAFC_ST_SWAP: begin
        // External clock must still run here on return to internal
        cnt_nxt = cnt_r + 3'd1;
        if (cnt_r == 3'(`MCSAFC_SWITCH_CYCLES - 1)) st_nxt = MCSAFC_ST_RUN;
      end
      default: st_nxt = MCSAFC_ST_RUN;
    endcase
  end

  // Modulator clock toggles each main cycle: half rate, 50% duty.
  // Looking at the next state parks it low on the same edge the gate
  // closes, so no short high phase escapes into the changeover.
  always_comb begin
    run_nxt = is_run(st_nxt);
    mod_nxt = run_nxt ? ~mod_r : 1'b0;
  end

  // Diagnostic tick runs regardless of main source selection
  always_comb begin
    dtick_nxt = (dcnt_r == 16'(DIAG_DIV - 1));
    dcnt_nxt  = dtick_nxt ? 16'h0000 : dcnt_r + 16'h0001;
  end

  // State registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_r    <= MCSAFC_ST_RUN;
      run_r   <= 1'b1;
      src_r   <= `MCSAFC_SRC_RESET;
      cnt_r   <= 3'd0;
      mod_r   <= 1'b0;
      dcnt_r  <= 16'h0000;
      dtick_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      run_r   <= run_nxt;
      src_r   <= src_nxt;
      cnt_r   <= cnt_nxt;
      mod_r   <= mod_nxt;
      dcnt_r  <= dcnt_nxt;
      dtick_r <= dtick_nxt;
    end
  end

  // Status outputs are registers
  always_comb begin
    ACTIVE_SOURCE  = src_r;
    MAIN_CLOCK_RUN = run_r;
    MOD_CLOCK      = mod_r;
    DIAG_TICK      = dtick_r;
  end

  // Two independent sections sharing this clock
  mcsafc_channel u_chan_a (
    .clk        (CLOCK),
    .rst        (RESET),
    .mux_sel    (MUX_SEL_A),
    .gain_sel   (GAIN_SEL_A),
    .switches_r (SWITCHES_A),
    .gain_r     (GAIN_A),
    .fsr_uv_r   (FSR_UV_A)
  );
  mcsafc_channel u_chan_b (
    .clk        (CLOCK),
    .rst        (RESET),
    .mux_sel    (MUX_SEL_B),
    .gain_sel   (GAIN_SEL_B),
    .switches_r (SWITCHES_B),
    .gain_r     (GAIN_B),
    .fsr_uv_r   (FSR_UV_B)
  );
endmodule : mcsafc_top

// >>> pkg/mcsafc_defines.svh
/*
  Constants for the main clock and shunt ADC front control block:
  clock-source codes, input-select codes, reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef MCSAFC_DEFINES_SVH
`define MCSAFC_DEFINES_SVH

// Clock source select values
`define MCSAFC_SRC_INTERNAL   1'b0
`define MCSAFC_SRC_EXTERNAL   1'b1
`define MCSAFC_SRC_RESET      1'b0

// Input-select codes
`define MCSAFC_MUX_NORMAL     2'h0
`define MCSAFC_MUX_SWAPPED    2'h1
`define MCSAFC_MUX_SHORT      2'h2
`define MCSAFC_MUX_TESTDAC    2'h3
`define MCSAFC_MUX_RESET      2'h0

// Gain-select reset code
`define MCSAFC_GAIN_RESET     2'h0

// Full-scale range in microvolts at gain 1 (1.25 V)
`define MCSAFC_FSR_UV         21'h1312d0

// Switchover settle count in main clock cycles
`define MCSAFC_SWITCH_CYCLES  4

`endif

// >>> pkg/mcsafc_pkg.sv
/*
  Types of the main clock and shunt ADC front control block.
  Assumes the defines header sits on the include path.
*/
package mcsafc_pkg;
  // Switchover state machine states
  typedef enum logic [1:0] {
    MCSAFC_ST_RUN  = 2'b00, // Stable on chosen source
    MCSAFC_ST_HOLD = 2'b01, // Gating the clock during changeover
    MCSAFC_ST_SWAP = 2'b10  // Source moved, waiting before release
  } mcsafc_state_t;
endpackage : mcsafc_pkg

// >>> tb/mcsafc_props.sv
/* Checker for the mcsafc_top ports: routing, gain, clock switchover.
   Assumes one CLOCK domain with a synchronous active-high RESET. */
`timescale 1ns/10ps
module mcsafc_props #(parameter int DIAG_DIV = 8) (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET,
  // Settings
  input wire logic        CLOCK_SOURCE,
  input wire logic [1:0]  CONVERTERS_ENABLE,
  input wire logic [1:0]  MUX_SEL_A,
  input wire logic [1:0]  GAIN_SEL_A,
  input wire logic [1:0]  MUX_SEL_B,
  input wire logic [1:0]  GAIN_SEL_B,
  // Observed outputs
  input wire logic        ACTIVE_SOURCE,
  input wire logic        MAIN_CLOCK_RUN,
  input wire logic        MOD_CLOCK,
  input wire logic        DIAG_TICK,
  input wire logic [4:0]  SWITCHES_A,
  input wire logic [4:0]  SWITCHES_B,
  input wire logic [5:0]  GAIN_A,
  input wire logic [5:0]  GAIN_B,
  input wire logic [20:0] FSR_UV_A,
  input wire logic [20:0] FSR_UV_B
);
  // Cycles since the last diagnostic tick; the check compares it with DIAG_DIV
  logic [16:0] gap_r;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gap_r <= 17'h00000;
    end else if (DIAG_TICK) begin
      gap_r <= 17'h00001;
    end else begin
      gap_r <= gap_r + 17'h00001;
    end
  end
  // Switch pattern {S1,S2,S3,S3n,S_TDAC} for an input code
  function automatic logic [4:0] sw(logic [1:0] m);
    return m[1] ? (m[0] ? 5'h05 : 5'h0c) : (m[0] ? 5'h12 : 5'h14);
  endfunction : sw
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  AST_SW_A: assert property (!$past(RESET) |-> SWITCHES_A == sw($past(MUX_SEL_A)))
    else $error("section A switches wrong");
  AST_SW_B: assert property (!$past(RESET) |-> SWITCHES_B == sw($past(MUX_SEL_B)))
    else $error("section B switches wrong");
  AST_GAIN: assert property (!$past(RESET) |-> GAIN_A == 6'h04 << $past(GAIN_SEL_A))
    else $error("gain wrong");
  AST_FSR: assert property (!$past(RESET) |-> FSR_UV_A == 21'h4c4b4 >> $past(GAIN_SEL_A))
    else $error("full scale wrong");
  AST_GAIN_B: assert property (!$past(RESET) |-> GAIN_B == 6'h04 << $past(GAIN_SEL_B))
    else $error("section B gain wrong");
  AST_FSR_B: assert property (!$past(RESET) |-> FSR_UV_B == 21'h4c4b4 >> $past(GAIN_SEL_B))
    else $error("section B full scale wrong");
  AST_RST: assert property ($past(RESET) |-> !ACTIVE_SOURCE && MAIN_CLOCK_RUN)
    else $error("reset source wrong");
  AST_MOD: assert property (!$past(RESET) && $past(MAIN_CLOCK_RUN) && MAIN_CLOCK_RUN
    |-> MOD_CLOCK != $past(MOD_CLOCK)) else $error("modulator clock stuck");
  AST_GATE: assert property (!MAIN_CLOCK_RUN |-> !MOD_CLOCK)
    else $error("modulator clock during changeover");
  AST_HOLD: assert property (MAIN_CLOCK_RUN && CONVERTERS_ENABLE != 2'h0
    |=> $stable(ACTIVE_SOURCE) && MAIN_CLOCK_RUN) else $error("switch while enabled");
  AST_TAKE: assert property (MAIN_CLOCK_RUN && CONVERTERS_ENABLE == 2'h0
    && CLOCK_SOURCE != ACTIVE_SOURCE |=> !MAIN_CLOCK_RUN [*5] ##1
    (MAIN_CLOCK_RUN && ACTIVE_SOURCE == $past(CLOCK_SOURCE, 6))) else $error("switchover wrong");
  AST_DIAG: assert property (DIAG_TICK == (int'(gap_r) == DIAG_DIV))
    else $error("diagnostic tick spacing wrong");
  // Main scenarios reached
  cover property ($rose(ACTIVE_SOURCE));
  cover property ($fell(ACTIVE_SOURCE));
  cover property (MUX_SEL_A == 2'h3 ##1 SWITCHES_A == 5'h05);
endmodule : mcsafc_props
bind mcsafc_top mcsafc_props #(.DIAG_DIV(DIAG_DIV)) i_props (.*);

// >>> tb/tb_top.sv
/* Self-checking bench for mcsafc_top.
   Assumes default DIAG_DIV and inputs driven at the falling edge. */
`timescale 1ns/10ps
module tb_top;
  logic        CLOCK = 0, RESET = 1, CLOCK_SOURCE = 0;
  logic [1:0]  CONVERTERS_ENABLE = 0, MUX_SEL_A = 0, GAIN_SEL_A = 0, MUX_SEL_B = 0, GAIN_SEL_B = 0;
  logic        ACTIVE_SOURCE, MAIN_CLOCK_RUN, MOD_CLOCK, DIAG_TICK;
  logic [4:0]  SWITCHES_A, SWITCHES_B;
  logic [5:0]  GAIN_A, GAIN_B;
  logic [20:0] FSR_UV_A, FSR_UV_B;
  int          fail_count = 0, n_tests = 0, t;
  bit          hung = 1'b0;
  logic [4:0]  sw_tab [4] = '{5'h14, 5'h12, 5'h0c, 5'h05};
  always #12.5 CLOCK = ~CLOCK;
  mcsafc_top i_dut (.*);
  task automatic cyc(int n);
    repeat (n) @(negedge CLOCK);
  endtask : cyc
  task automatic chk(string nm, logic [20:0] e, logic [20:0] g);
    n_tests++;
    if ((^g === 1'bx) || (g !== e)) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Each code on both sections, crossed so A and B differ
  task automatic t_front;
    for (int i = 0; i < 4; i++) begin
      MUX_SEL_A = i[1:0];
      MUX_SEL_B = 2'(3 - i);
      GAIN_SEL_A = i[1:0];
      GAIN_SEL_B = 2'(3 - i);
      cyc(1);
      chk("sw A", sw_tab[i], SWITCHES_A);
      chk("sw B", sw_tab[3 - i], SWITCHES_B);
      chk("gain A", 6'h04 << i, GAIN_A);
      chk("gain B", 6'h20 >> i, GAIN_B);
      chk("fsr A", 21'h4c4b4 >> i, FSR_UV_A);
      chk("fsr B", 21'h4c4b4 >> (3 - i), FSR_UV_B);
    end
    $display("front done");
  endtask : t_front
  // Refused while enabled, taken once both enables drop
  task automatic t_src(logic s);
    logic m;
    CONVERTERS_ENABLE = 2'h1;
    CLOCK_SOURCE = s;
    cyc(8);
    chk("refused", !s, ACTIVE_SOURCE);
    CONVERTERS_ENABLE = 2'h0;
    cyc(1);
    chk("gated", 0, MAIN_CLOCK_RUN);
    for (int k = 0; k < 20 && MAIN_CLOCK_RUN !== 1'b1; k++) cyc(1);
    if (MAIN_CLOCK_RUN !== 1'b1) begin
      fail_count++;
      hung = 1'b1;
      $display("CHECK FAILED run exp 1 got %b", MAIN_CLOCK_RUN);
      return;
    end
    chk("source", s, ACTIVE_SOURCE);
    m = MOD_CLOCK;
    cyc(1);
    chk("mod", !m, MOD_CLOCK);
    $display("source %0d done", s);
  endtask : t_src
  // Reset in mid-run from the external source returns to the internal one
  task automatic t_rst;
    CONVERTERS_ENABLE = 2'h3;
    RESET = 1'b1;
    cyc(2);
    chk("rst src", 0, ACTIVE_SOURCE);
    chk("rst run", 1, MAIN_CLOCK_RUN);
    chk("rst mod", 0, MOD_CLOCK);
    chk("rst gain", 6'h04, GAIN_A);
    chk("rst fsr", 21'h4c4b4, FSR_UV_B);
    RESET = 1'b0;
    cyc(8);
    chk("kept src", 0, ACTIVE_SOURCE);
    $display("reset done");
  endtask : t_rst
  initial begin
    cyc(8);
    chk("rst src", 0, ACTIVE_SOURCE);
    chk("rst sw", 5'h14, SWITCHES_A);
    RESET = 0;
    t_front();
    t_src(1'b1);
    t_rst();
    if (!hung) t_src(1'b1);
    if (!hung) t_src(1'b0);
    t = 0;
    repeat (64) begin
      cyc(1);
      t += int'(DIAG_TICK === 1'b1);
    end
    chk("ticks", 8, t);
    give_verdict();
  end
endmodule : tb_top
